// >>> src/slfb_regs.svh
// Frame layout, timing and stuffing constants for the line frame builder
`ifndef SLFB_REGS_SVH
`define SLFB_REGS_SVH
// ----------------------------------------
// Frame layout
// ----------------------------------------
`define SLFB_SYNC_LEN   14'h000e
`define SLFB_OH_G0      14'h0002
`define SLFB_OH_GN      14'h000a
`define SLFB_BLK_2P     14'h0091
`define SLFB_BLK_1P     14'h0121
`define SLFB_BASE_2P    14'h1b5e
`define SLFB_BASE_1P    14'h365e
`define SLFB_NOM_2P     21'h001b60
`define SLFB_NOM_1P     21'h003660
`define SLFB_CORE_2P    14'h1b00
`define SLFB_CORE_1P    14'h3600
`define SLFB_Z_TOTAL    6'h30
`define SLFB_Z_RSVD     6'h08
`define SLFB_SYNC_WORD  14'h0cf5
// ----------------------------------------
// Timing and stuffing
// ----------------------------------------
`define SLFB_FRAME_NS   32'h005b8d80
`define SLFB_CLK_NS     32'h00000004
`define SLFB_DEADBAND_Q 8'sh04
`define SLFB_ALIGN_N    2'h2
`endif

// >>> src/slfb_pkg.sv
// Types shared by the line frame builder
package slfb_pkg;
  // ----------------------------------------
  // Kind of a bit position in the frame
  // ----------------------------------------
  typedef enum logic [2:0] {
    SLFB_K_SYNC,
    SLFB_K_OH,
    SLFB_K_Z,
    SLFB_K_CORE,
    SLFB_K_STUFF
  } slfb_kind_t;
  // Decoded position: kind and running index
  typedef struct packed {
    slfb_kind_t  kind;
    logic [5:0]  idx;
  } slfb_pos_t;
  // Per-pair transmit inputs from the application side
  typedef struct packed {
    logic [31:0] oh_bits;
    logic [31:0] oh_used;
    logic [39:0] aux_bits;
    logic [39:0] aux_used;
    logic        core_bit;
  } slfb_lane_in_t;
  // Receiver state
  typedef enum logic {SLFB_RX_HUNT, SLFB_RX_TRACK} slfb_rx_st_t;
endpackage

// >>> src/slfb_framer.sv
// Line frame builder and parser for one- or two-pair subscriber line systems
// Function
// - Nominal frame lasts six milliseconds
// - Two-pair frames 7006, 7008 or 7010 bits
// - One-pair frames 13918, 13920 or 13922 bits
// - Absorb timing by 0-2 trailing stuff pairs
// - Exchange side: both pairs share frame timing
// - Pair frame starts skew under one symbol
// - Same stuffing decision on both pairs
// - Two-pair: sync, 2 overhead, 145-bit blocks
// - One-pair: same, 289-bit blocks
// - Later groups: ten overhead, twelve blocks
// - 864 or 1728 core bytes per frame
// - Auxiliary bits one to eight sent ONE
// - Aux bits 9-48 passed, unused sent ONE
// - 48 aux bits per frame, 8 kbit/s
// - One stuff pair default, drop or add
// - Stuffing dead band of two unit intervals
// - Receiver sizes frame from next sync
// - Framing only in normal operation
// - Plain bits before scrambler, after descrambler
// - All frame bits go to scrambler
// - Unused overhead positions sent ONE
`timescale 1ns/1ps
`include "slfb_regs.svh"
module slfb_framer
  import slfb_pkg::*;
#(
  parameter int          FRAME_CYCLES = `SLFB_FRAME_NS / `SLFB_CLK_NS,
  parameter logic [13:0] SYNC_WORD    = `SLFB_SYNC_WORD
) (
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic                normal_op,
  input  wire logic                one_pair,
  input  wire logic signed [7:0]   phase_err,
  input  wire slfb_lane_in_t [1:0] lane_in,
  output logic [1:0]               tx_bit_r,
  output logic                     tx_vld_r,
  output logic                     tx_frame_start_r,
  output logic [1:0]               core_take_r,
  output logic [1:0]               tx_stuff_r,
  input  wire logic                rx_bit,
  input  wire logic                rx_tick,
  output logic                     rx_core_bit_r,
  output logic                     rx_core_vld_r,
  output logic                     rx_z_bit_r,
  output logic                     rx_z_vld_r,
  output logic [5:0]               rx_z_idx_r,
  output logic                     rx_aligned_r,
  output logic [13:0]              rx_len_r,
  output logic                     rx_len_vld_r
);
  // ----------------------------------------
  // Position decode
  // ----------------------------------------
  // Walks the four groups of twelve blocks; shared by both directions
  function automatic slfb_pos_t pos_decode(input logic [13:0] pos, input logic op);
    logic [13:0] p;
    logic [13:0] blk;
    logic [13:0] ohn;
    logic [5:0]  zb;
    logic [5:0]  ob;
    logic        done;
    slfb_pos_t   r;
    p    = pos - `SLFB_SYNC_LEN;
    blk  = op ? `SLFB_BLK_1P : `SLFB_BLK_2P;
    zb   = 6'h00;
    ob   = 6'h00;
    done = 1'b0;
    r    = '{kind: SLFB_K_STUFF, idx: 6'h00};
    if (pos < `SLFB_SYNC_LEN) begin
      r    = '{kind: SLFB_K_SYNC, idx: pos[5:0]};
      done = 1'b1;
    end
    for (int g = 0; g < 4; g++) begin
      ohn = (g == 0) ? `SLFB_OH_G0 : `SLFB_OH_GN;
      if (!done && p < ohn) begin
        r    = '{kind: SLFB_K_OH, idx: ob + p[5:0]};
        done = 1'b1;
      end else if (!done) begin
        p = p - ohn;
      end
      ob = ob + ohn[5:0];
      for (int b = 0; b < 12; b++) begin
        if (!done && p < blk) begin
          // Block opens with its aux bit, then core bytes
          r.kind = (p == 14'h0000) ? SLFB_K_Z : SLFB_K_CORE;
          r.idx  = zb;
          done   = 1'b1;
        end else if (!done) begin
          p = p - blk;
        end
        zb = zb + 6'h01;
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // Line bit timing
  // ----------------------------------------
  // Fractional divider: nominal bits per frame per FRAME_CYCLES clocks,
  // so the nominal frame lasts exactly 6 ms; one source feeds both pairs
  logic [20:0] acc_r;   // Divider phase
  logic [20:0] acc_nxt;
  logic        tick_r;  // One line bit period elapsed
  logic        tick_nxt;
  logic [20:0] nom;     // Nominal bits per frame

  always_comb begin
    nom      = one_pair ? `SLFB_NOM_1P : `SLFB_NOM_2P;
    acc_nxt  = acc_r + nom;
    tick_nxt = 1'b0;
    if (acc_nxt >= FRAME_CYCLES[20:0]) begin
      acc_nxt  = acc_nxt - FRAME_CYCLES[20:0];
      tick_nxt = 1'b1;
    end
    if (!normal_op) begin
      acc_nxt  = '0;
      tick_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      acc_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      acc_r  <= acc_nxt;
      tick_r <= tick_nxt;
    end
  end

  // ----------------------------------------
  // Transmit framer
  // ----------------------------------------
  // One position counter serves both pairs, so sync words line up
  // within one bit and one stuffing count goes to both
  logic [13:0] tx_pos_r;    // Next bit position
  logic [13:0] tx_pos_nxt;
  logic [1:0]  stuff_nxt;
  logic [1:0]  bit_nxt;
  logic        vld_nxt;
  logic        start_nxt;
  logic [1:0]  take_nxt;
  logic [13:0] tx_len;      // Length of the frame in flight
  slfb_pos_t   tx_dec;
  slfb_kind_t  tx_kind_r;   // Kind of the bit on tx_bit_r
  slfb_kind_t  kind_nxt;
  logic [5:0]  tx_idx_r;    // Index of the bit on tx_bit_r
  logic [5:0]  aidx;

  always_comb begin
    tx_dec     = pos_decode(tx_pos_r, one_pair);
    tx_len     = (one_pair ? `SLFB_BASE_1P : `SLFB_BASE_2P)
               + {11'h000, tx_stuff_r, 1'b0};
    tx_pos_nxt = tx_pos_r;
    stuff_nxt  = tx_stuff_r;
    bit_nxt    = 2'b11;
    vld_nxt    = 1'b0;
    start_nxt  = 1'b0;
    take_nxt   = 2'b00;
    kind_nxt   = tx_kind_r;
    aidx       = tx_dec.idx - `SLFB_Z_RSVD;
    if (!normal_op) begin
      tx_pos_nxt = '0;
      stuff_nxt  = 2'h1;
    end else if (tick_r) begin
      vld_nxt    = 1'b1;
      kind_nxt   = tx_dec.kind;
      tx_pos_nxt = (tx_pos_r == tx_len - 14'h0001) ? 14'h0000 : tx_pos_r + 14'h0001;
      if (tx_pos_r == 14'h0000) begin
        start_nxt = 1'b1;
        // Dead band: one pair unless phase is clearly off
        if (phase_err > `SLFB_DEADBAND_Q) begin
          stuff_nxt = 2'h2;
        end else if (phase_err < -`SLFB_DEADBAND_Q) begin
          stuff_nxt = 2'h0;
        end else begin
          stuff_nxt = 2'h1;
        end
      end
      for (int l = 0; l < 2; l++) begin
        unique case (tx_dec.kind)
          SLFB_K_SYNC: bit_nxt[l] = SYNC_WORD[13 - tx_dec.idx];
          SLFB_K_OH: begin
            // Unassigned overhead positions idle at ONE
            bit_nxt[l] = lane_in[l].oh_used[tx_dec.idx[4:0]]
                       ? lane_in[l].oh_bits[tx_dec.idx[4:0]] : 1'b1;
          end
          SLFB_K_Z: begin
            if (tx_dec.idx < `SLFB_Z_RSVD) begin
              bit_nxt[l] = 1'b1;
            end else begin
              bit_nxt[l] = lane_in[l].aux_used[aidx]
                         ? lane_in[l].aux_bits[aidx] : 1'b1;
            end
          end
          SLFB_K_CORE: begin
            bit_nxt[l]  = lane_in[l].core_bit;
            take_nxt[l] = 1'b1;
          end
          SLFB_K_STUFF: bit_nxt[l] = 1'b1;
        endcase
      end
      // Second pair idles at ONE in one-pair mode
      if (one_pair) begin
        bit_nxt[1]  = 1'b1;
        take_nxt[1] = 1'b0;
      end
    end
  end

  // Plain bits only; the scrambler downstream sees every bit
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_pos_r         <= '0;
      tx_stuff_r       <= 2'h1;
      tx_bit_r         <= 2'b11;
      tx_vld_r         <= 1'b0;
      tx_frame_start_r <= 1'b0;
      core_take_r      <= 2'b00;
      tx_kind_r        <= SLFB_K_STUFF;
      tx_idx_r         <= '0;
    end else begin
      tx_pos_r         <= tx_pos_nxt;
      tx_stuff_r       <= stuff_nxt;
      tx_bit_r         <= bit_nxt;
      tx_vld_r         <= vld_nxt;
      tx_frame_start_r <= start_nxt;
      core_take_r      <= take_nxt;
      tx_kind_r        <= kind_nxt;
      tx_idx_r         <= tick_r ? tx_dec.idx : tx_idx_r;
    end
  end

  // ----------------------------------------
  // Receive deframer
  // ----------------------------------------
  // Sync may end 14, 16 or 18 bits past the fixed part of the frame;
  // the end found sets the length, so payload needs no delay line
  slfb_rx_st_t rx_st_r;
  slfb_rx_st_t rx_st_nxt;
  logic [13:0] sh_r;       // Last fourteen received bits
  logic [13:0] sh_nxt;
  logic [13:0] rx_pos_r;   // Position of the next received bit
  logic [13:0] rx_pos_nxt;
  logic [1:0]  good_r;     // Consecutive good frame ends
  logic [1:0]  good_nxt;
  logic [13:0] rx_base;
  logic [13:0] rel;
  slfb_pos_t   rx_dec;
  logic        c_bit, c_vld, z_bit, z_vld, al_nxt, lv_nxt;
  logic [5:0]  z_idx;
  logic [13:0] len_nxt;

  always_comb begin
    rx_base    = one_pair ? `SLFB_BASE_1P : `SLFB_BASE_2P;
    rx_dec     = pos_decode(rx_pos_r, one_pair);
    rel        = rx_pos_r - rx_base;
    sh_nxt     = sh_r;
    rx_st_nxt  = rx_st_r;
    rx_pos_nxt = rx_pos_r;
    good_nxt   = good_r;
    c_bit      = rx_bit;
    c_vld      = 1'b0;
    z_bit      = rx_bit;
    z_vld      = 1'b0;
    z_idx      = rx_z_idx_r;
    al_nxt     = rx_aligned_r;
    lv_nxt     = 1'b0;
    len_nxt    = rx_len_r;
    if (!normal_op) begin
      rx_st_nxt = SLFB_RX_HUNT;
      al_nxt    = 1'b0;
      good_nxt  = '0;
    end else if (rx_tick) begin
      sh_nxt = {sh_r[12:0], rx_bit};
      unique case (rx_st_r)
        SLFB_RX_HUNT: begin
          if (sh_nxt == SYNC_WORD) begin
            rx_st_nxt  = SLFB_RX_TRACK;
            rx_pos_nxt = `SLFB_SYNC_LEN;
            good_nxt   = '0;
          end
        end
        SLFB_RX_TRACK: begin
          rx_pos_nxt = rx_pos_r + 14'h0001;
          if (rx_pos_r < rx_base) begin
            c_vld = (rx_dec.kind == SLFB_K_CORE);
            z_vld = (rx_dec.kind == SLFB_K_Z);
            z_idx = rx_dec.idx;
          end else if (sh_nxt == SYNC_WORD && rel[0] && rel >= 14'h000d) begin
            // Sync of the next frame closes this one
            len_nxt    = rx_pos_r - 14'h000d;
            lv_nxt     = 1'b1;
            rx_pos_nxt = `SLFB_SYNC_LEN;
            if (good_r != `SLFB_ALIGN_N) begin
              good_nxt = good_r + 2'h1;
            end
            al_nxt = (good_nxt == `SLFB_ALIGN_N);
          end else if (rel >= 14'h0011) begin
            // No sync at any legal length: hunt again
            rx_st_nxt = SLFB_RX_HUNT;
            al_nxt    = 1'b0;
            good_nxt  = '0;
          end
        end
      endcase
    end
  end

  // Works on the descrambled bit stream
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_st_r       <= SLFB_RX_HUNT;
      sh_r          <= '0;
      rx_pos_r      <= '0;
      good_r        <= '0;
      rx_core_bit_r <= 1'b0;
      rx_core_vld_r <= 1'b0;
      rx_z_bit_r    <= 1'b0;
      rx_z_vld_r    <= 1'b0;
      rx_z_idx_r    <= '0;
      rx_aligned_r  <= 1'b0;
      rx_len_r      <= '0;
      rx_len_vld_r  <= 1'b0;
    end else begin
      rx_st_r       <= rx_st_nxt;
      sh_r          <= sh_nxt;
      rx_pos_r      <= rx_pos_nxt;
      good_r        <= good_nxt;
      rx_core_bit_r <= c_bit;
      rx_core_vld_r <= c_vld;
      rx_z_bit_r    <= z_bit;
      rx_z_vld_r    <= z_vld;
      rx_z_idx_r    <= z_idx;
      rx_aligned_r  <= al_nxt;
      rx_len_r      <= len_nxt;
      rx_len_vld_r  <= lv_nxt;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Helper counts of bits, aux bits and core bits per frame
  logic [13:0] h_bits, h_core;
  logic [5:0]  h_z;
  logic        h_seen;
  always_ff @(posedge clk) begin
    if (srst || !normal_op) begin
      h_bits <= '0;
      h_core <= '0;
      h_z    <= '0;
      h_seen <= 1'b0;
    end else if (tx_frame_start_r) begin
      h_bits <= 14'h0001;
      h_core <= '0;
      h_z    <= '0;
      h_seen <= 1'b1;
    end else if (tx_vld_r) begin
      h_bits <= h_bits + 14'h0001;
      h_core <= h_core + {13'h0000, core_take_r[0]};
      h_z    <= h_z + {5'h00, tx_kind_r == SLFB_K_Z};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_len_two_pair: assert property (tx_frame_start_r && h_seen && !one_pair
    |-> h_bits inside {14'h1b5e, 14'h1b60, 14'h1b62})
    else $error("two-pair frame length illegal");
  a_len_one_pair: assert property (tx_frame_start_r && h_seen && one_pair
    |-> h_bits inside {14'h365e, 14'h3660, 14'h3662})
    else $error("one-pair frame length illegal");
  a_core_per_frame: assert property (tx_frame_start_r && h_seen
    |-> h_core == (one_pair ? `SLFB_CORE_1P : `SLFB_CORE_2P))
    else $error("core bit count per frame wrong");
  a_aux_per_frame: assert property (tx_frame_start_r && h_seen
    |-> h_z == `SLFB_Z_TOTAL)
    else $error("aux bit count per frame wrong");
  a_z_reserved: assert property (tx_vld_r && tx_kind_r == SLFB_K_Z
    && tx_idx_r < `SLFB_Z_RSVD |-> tx_bit_r == 2'b11)
    else $error("reserved aux bit not ONE");
  a_stuff_band: assert property (normal_op && tick_r && tx_pos_r == 14'h0000
    && phase_err <= `SLFB_DEADBAND_Q && phase_err >= -`SLFB_DEADBAND_Q
    |=> tx_stuff_r == 2'h1)
    else $error("stuffing changed inside dead band");
  a_pairs_same: assert property (tx_vld_r && !one_pair
    && tx_kind_r inside {SLFB_K_SYNC, SLFB_K_STUFF}
    |-> tx_bit_r[0] == tx_bit_r[1])
    else $error("pairs differ in sync or stuffing");
  a_sync_first: assert property (tx_frame_start_r |-> tx_bit_r[0] == SYNC_WORD[13]
    ##0 tx_kind_r == SLFB_K_SYNC)
    else $error("frame does not open with sync");
  a_idle_off: assert property (!normal_op |=> !tx_vld_r && !rx_core_vld_r)
    else $error("framing active outside normal operation");
  a_rx_len: assert property (rx_len_vld_r |-> (rx_len_r - rx_base) inside
    {14'h0000, 14'h0002, 14'h0004})
    else $error("received frame length illegal");
  a_rx_align: assert property ($rose(rx_aligned_r) |-> rx_len_vld_r
    ##0 $past(rx_st_r) == SLFB_RX_TRACK)
    else $error("alignment without frame end");

  c_stuff_none: cover property (tx_frame_start_r ##1 tx_stuff_r == 2'h0);
  c_stuff_two:  cover property (tx_frame_start_r ##1 tx_stuff_r == 2'h2);
  c_rx_aligned: cover property ($rose(rx_aligned_r));
  c_rx_lost:    cover property ($fell(rx_aligned_r) && normal_op);
endmodule

// >>> bench/slfb_far_end.sv
// Far-end model: returns the pair-0 line stream as descrambled receive bits
`timescale 1ns/1ps
module slfb_far_end (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic line_bit,  // Plain frame bit from the framer
  input  wire logic line_vld,  // One-cycle strobe of that bit
  input  wire logic corrupt,   // Inverts bits to spoil a sync word
  input  wire logic slow,      // Answer one cycle later
  output logic      rx_bit,
  output logic      rx_tick
);
  logic hold_bit_r;  // Bit kept for the late answer
  logic hold_vld_r;  // Strobe kept for the late answer
  // ----------------------------------------
  // Return path
  // ----------------------------------------
  // Between strobes the line toggles, so a stale bit never looks like data
  always @(posedge clk) begin
    hold_bit_r <= line_bit ^ corrupt;
    hold_vld_r <= line_vld & ~srst;
    if (srst) begin
      rx_tick <= 1'b0;
      rx_bit  <= 1'b0;
    end else if (slow ? hold_vld_r : line_vld) begin
      rx_tick <= 1'b1;
      rx_bit  <= slow ? hold_bit_r : (line_bit ^ corrupt);
    end else begin
      rx_tick <= 1'b0;
      rx_bit  <= ~rx_bit;
    end
  end
endmodule

// >>> bench/dsl_line_frame_builder_test.sv
// Testbench: line frame builder looped back through the far-end model
`timescale 1ns/1ps
`include "slfb_regs.svh"
module dsl_line_frame_builder_test import slfb_pkg::*; ;
  localparam int FC = 28000;  // Short frame period, still at least two clocks per line bit
  logic                clk = 1'b0;
  logic                srst = 1'b1;
  logic                normal_op = 1'b0;
  logic                one_pair = 1'b0;
  logic                slow = 1'b0;
  logic                corrupt = 1'b0;
  logic signed [7:0]   phase_err = 8'sh00;
  slfb_lane_in_t [1:0] lane_in;
  logic [1:0]          tx_bit_r, core_take_r, tx_stuff_r;
  logic                tx_vld_r, tx_frame_start_r, rx_bit, rx_tick;
  logic                rx_core_bit_r, rx_core_vld_r, rx_z_bit_r, rx_z_vld_r;
  logic [5:0]          rx_z_idx_r;
  logic                rx_aligned_r, rx_len_vld_r;
  logic [13:0]         rx_len_r;
  logic [13:0]         rq[$];      // Receive lengths seen
  int                  bad_count, n_tests, cyc, pos, flen, fdur, fst, fdone, rc;
  int                  tk[2], base[2], ftk[2];  // Core takes: total, frame base, per frame
  bit                  mon_en, mon_on, cut;
  bit                  cut_on;     // Cut applies from the next frame start only
  bit                  rx_on = 1'b1;

  slfb_framer #(.FRAME_CYCLES(FC), .SYNC_WORD(`SLFB_SYNC_WORD)) uut (
    .clk(clk), .srst(srst), .normal_op(normal_op), .one_pair(one_pair),
    .phase_err(phase_err), .lane_in(lane_in), .tx_bit_r(tx_bit_r), .tx_vld_r(tx_vld_r),
    .tx_frame_start_r(tx_frame_start_r), .core_take_r(core_take_r),
    .tx_stuff_r(tx_stuff_r), .rx_bit(rx_bit), .rx_tick(rx_tick),
    .rx_core_bit_r(rx_core_bit_r), .rx_core_vld_r(rx_core_vld_r),
    .rx_z_bit_r(rx_z_bit_r), .rx_z_vld_r(rx_z_vld_r), .rx_z_idx_r(rx_z_idx_r),
    .rx_aligned_r(rx_aligned_r), .rx_len_r(rx_len_r), .rx_len_vld_r(rx_len_vld_r));

  slfb_far_end far (.clk(clk), .srst(srst), .line_bit(tx_bit_r[0]), .line_vld(tx_vld_r),
    .corrupt(corrupt), .slow(slow), .rx_bit(rx_bit), .rx_tick(rx_tick));

  // 250 MHz clock
  always #2 clk = ~clk;

  // ----------------------------------------
  // Expected frame content
  // ----------------------------------------
  // Core stream pattern, different per pair so swapped pairs show
  function automatic logic cpat(input int l, input int i);
    return logic'(i[0] ^ i[3] ^ i[6] ^ l[0]);
  endfunction

  // Auxiliary bit z (0 = first); the reserved eight are always ONE
  function automatic logic zbit(input int l, input int z);
    if (z < 8) return 1'b1;
    return lane_in[l].aux_used[z-8] ? lane_in[l].aux_bits[z-8] : 1'b1;
  endfunction

  // Bit at frame position p of pair l; b is the core take count at frame start
  function automatic logic exp_bit(input int l, input int p, input int b);
    int blk, oi, zi, ci, n;
    blk = one_pair ? 288 : 144;
    oi = 0;
    zi = 0;
    ci = 0;
    if (l == 1 && one_pair) return 1'b1;
    if (p < 14) return logic'(`SLFB_SYNC_WORD >> (13 - p));
    p -= 14;
    for (int g = 0; g < 4; g++) begin
      n = (g == 0) ? 2 : 10;
      if (p < n) return lane_in[l].oh_used[oi+p] ? lane_in[l].oh_bits[oi+p] : 1'b1;
      p -= n;
      oi += n;
      for (int k = 0; k < 12; k++) begin
        if (p == 0) return zbit(l, zi);
        if (p <= blk) return cpat(l, b + ci + p - 1);
        p -= blk + 1;
        zi++;
        ci += blk;
      end
    end
    // Stuffing bits are ONE
    return 1'b1;
  endfunction

  task automatic chk(input bit ok, input string m);
    n_tests++;
    if (!ok) begin
      bad_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  task automatic end_of_test();
    $display("bad_count=%0d n_tests=%0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Monitor: core feed, frame bits, receive side
  // ----------------------------------------
  always @(posedge clk) begin
    cyc++;
    for (int l = 0; l < 2; l++) begin
      if (core_take_r[l]) begin
        tk[l]++;
        lane_in[l].core_bit <= cpat(l, tk[l]);
      end
    end
    if (tx_vld_r) begin
      if (tx_frame_start_r) begin
        flen = pos;
        fdur = cyc - fst;
        fst = cyc;
        fdone++;
        pos = 0;
        mon_on = mon_en;
        cut_on = cut;
        for (int l = 0; l < 2; l++) begin
          ftk[l] = tk[l] - base[l];
          base[l] = tk[l];
        end
      end
      for (int l = 0; l < 2; l++) begin
        if (mon_on) chk(tx_bit_r[l] === exp_bit(l, pos, base[l]), "frame bit");
      end
      pos++;
    end
    // Spoil the sync word of the frame after the cut is armed
    corrupt <= cut_on && pos < 14;
    if (rx_len_vld_r) rq.push_back(rx_len_r);
    if (rx_on && rx_core_vld_r) begin
      chk(rx_core_bit_r === cpat(0, rc), "rx core bit");
      rc++;
    end
    if (rx_on && rx_z_vld_r) chk(rx_z_bit_r === zbit(0, int'(rx_z_idx_r)), "rx aux bit");
  end

  // Bounded wait for the n-th frame start
  task automatic wait_fs(input int n);
    for (int i = 0; i < 2 * FC && fdone < n; i++) @(posedge clk);
    if (fdone < n) begin
      chk(1'b0, "frame start missing");
      end_of_test();
    end
    repeat (2) @(posedge clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(tx_bit_r === 2'h3 && tx_vld_r === 1'b0 && tx_stuff_r === 2'h1, "tx reset");
    chk(rx_aligned_r === 1'b0 && rx_len_vld_r === 1'b0, "rx reset");
  endtask

  // Three frames: dead-band edge, drop a pair, add a pair
  task automatic t_frames();
    mon_en = 1'b1;
    phase_err <= 8'sh04;
    slow <= 1'b1;
    normal_op <= 1'b1;
    wait_fs(1);
    chk(tx_stuff_r === 2'h1, "default pair");
    phase_err <= -8'sh05;
    wait_fs(2);
    chk(flen == 32'h1b60, "two-pair length");
    chk(fdur >= FC - 8 && fdur <= FC + 8, "frame period");
    chk(ftk[0] == 32'h1b00 && ftk[1] == 32'h1b00, "core per pair");
    chk(tx_stuff_r === 2'h0, "pair dropped");
    phase_err <= 8'sh05;
    wait_fs(3);
    chk(flen == 32'h1b5e && ftk[0] == 32'h1b00, "short frame");
    chk(tx_stuff_r === 2'h2, "pair added");
    phase_err <= 8'sh00;
    cut = 1'b1;
    wait_fs(4);
    rx_on = 1'b0;
    chk(flen == 32'h1b62, "long frame");
    chk(rq.size() >= 2 && rq[0] === 14'h1b60 && rq[1] === 14'h1b5e, "rx lengths");
    chk(rx_aligned_r === 1'b1, "aligned");
  endtask

  // Spoiled sync word at frame end drops alignment
  task automatic t_lose_sync();
    for (int i = 0; i < 400 && rx_aligned_r === 1'b1; i++) @(posedge clk);
    chk(rx_aligned_r === 1'b0, "alignment kept");
    cut = 1'b0;
  endtask

  // Outside normal operation nothing is framed
  task automatic t_idle();
    int n;
    n = 0;
    normal_op <= 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 2000; i++) begin
      @(posedge clk);
      if (tx_vld_r === 1'b1) n++;
    end
    chk(n == 0 && rx_aligned_r === 1'b0, "idle");
  endtask

  // One-pair layout into the third block, prompt far end
  task automatic t_one_pair();
    one_pair <= 1'b1;
    slow <= 1'b0;
    @(posedge clk);
    normal_op <= 1'b1;
    wait_fs(fdone + 1);
    for (int i = 0; i < 4000 && pos < 620; i++) @(posedge clk);
    chk(pos >= 620, "one-pair bits");
  endtask

  initial begin
    lane_in[0] = '{32'h5a3c96e1, 32'hffff0f0f, 40'ha5c3e17b29, 40'hff00fff0f0, 1'b0};
    lane_in[1] = '{32'h0f1e2d3c, 32'h00ffff00, 40'h3c5a69f0e1, 40'h0f0f0ff0ff, 1'b1};
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    t_frames();
    t_lose_sync();
    t_idle();
    t_one_pair();
    end_of_test();
  end
endmodule
